// ---- logic/pwm_regs_pkg.sv ----
package pwm_regs_pkg;
  localparam int unsigned NUM_CHANNELS          = 3;
  localparam int unsigned ADDR_WIDTH            = 8;
  // Channel block layout: byte address = CHANNEL_BASE + channel * CHANNEL_STRIDE + field offset
  localparam logic [7:0]  CHANNEL_BASE          = 8'h00;
  localparam logic [7:0]  CHANNEL_STRIDE        = 8'h10;
  localparam logic [7:0]  TIMER_COUNT_LOW_OFF   = 8'h00;
  localparam logic [7:0]  TIMER_COUNT_HIGH_OFF  = 8'h04;
  localparam logic [7:0]  CHANNEL_CONTROL_OFF   = 8'h08;
  localparam logic [7:0]  CHANNEL_LOAD_CTRL_OFF = 8'h0c;
  localparam logic [7:0]  SHARED_ENABLE_ADDR    = 8'h30;
  localparam logic [7:0]  SHARED_LOAD_ADDR      = 8'h34;
  localparam logic [7:0]  SHARED_OUTPUT_ADDR    = 8'h38;
  localparam logic [7:0]  LOAD_DONE_ADDR        = 8'h3c;
  // Field positions
  localparam int unsigned CONTROL_ENABLE_BIT    = 7;
  localparam int unsigned CONTROL_OUTPUT_BIT    = 5;
  localparam int unsigned LOAD_ARMED_BIT        = 7;
  localparam int unsigned MIRROR_WIDTH          = 3;
  // Reset values
  localparam logic [2:0]  MIRROR_RESET          = 3'h0;
  localparam logic [1:0]  RESP_OKAY             = 2'h0;
  localparam logic [1:0]  RESP_SLVERR           = 2'h2;
  typedef enum logic [1:0] {
    bus_idle  = 2'b00,
    bus_resp  = 2'b01
  } write_state_t;
endpackage

// ---- logic/pwm_timer_mirror_regs.sv ----
// What this block does
// R01: Each channel's timer count high byte reads and writes counter bits 15 to 8.
// R02: Each channel's timer count low byte reads and writes counter bits 7 to 0.
// R03: Shared enable view bits 2..0 mirror control bit 7 of channels 2..0.
// R04: Shared load-armed view bits 2..0 mirror load control bit 7 of channels 2..0.
// R05: Shared output view bits 2..0 mirror control bit 5 of channels 2..0.
// R06: Bits 7..3 of the shared views ignore writes and read zero.
// R07: Timer bytes survive reset; mirror bits clear to zero on every reset.
// R08: Load-armed clears after a reload completes; software may clear it too.
// R09: Mirror and source share one flop, so either write updates both views.
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
module pwm_timer_mirror_regs
  import pwm_regs_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic [2:0]            timer_tick,
  input  wire logic [2:0]            reload_done,
  output logic [2:0]                 channel_enable,
  output logic [2:0]                 channel_load_armed,
  output logic [2:0]                 channel_output_level
);

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              aw_held;
    logic              w_held;
    logic [7:0]        aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    write_state_t      wstate;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [2:0]        enable;
    logic [2:0]        load_armed;
    logic [2:0]        out_level;
    logic [2:0][15:0]  count;
  } state_t;

  state_t s;
  state_t next_s;

  // Channel index of an address inside a channel block, or 3 when outside
  function automatic logic [1:0] chan_of(input logic [7:0] a);
    logic [1:0] c;
    c = 2'd3;
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      if (a[7:4] == 4'(i) + CHANNEL_BASE[7:4]) begin
        c = 2'(i);
      end
    end
    return c;
  endfunction

  function automatic logic [7:0] field_of(input logic [7:0] a);
    return {4'h0, a[3:0]};
  endfunction

  function automatic logic known(input logic [7:0] a);
    logic k;
    k = (chan_of(a) != 2'd3) && (a[1:0] == 2'b00);
    k = k || a == SHARED_ENABLE_ADDR || a == SHARED_LOAD_ADDR;
    k = k || a == SHARED_OUTPUT_ADDR || a == LOAD_DONE_ADDR;
    return k;
  endfunction

  function automatic logic [31:0] read_word(input state_t st, input logic [7:0] a);
    logic [31:0] d;
    logic [1:0]  c;
    d = 32'h0;
    c = chan_of(a);
    if (c != 2'd3) begin
      unique case (field_of(a))
        TIMER_COUNT_LOW_OFF:   d[7:0] = st.count[c][7:0];   // see R02
        TIMER_COUNT_HIGH_OFF:  d[7:0] = st.count[c][15:8];  // see R01
        CHANNEL_CONTROL_OFF: begin
          d[CONTROL_ENABLE_BIT] = st.enable[c];
          d[CONTROL_OUTPUT_BIT] = st.out_level[c];
        end
        CHANNEL_LOAD_CTRL_OFF: d[LOAD_ARMED_BIT] = st.load_armed[c];
        default:               d = 32'h0;
      endcase
    end else if (a == SHARED_ENABLE_ADDR) begin
      d[2:0] = st.enable;      // see R03
    end else if (a == SHARED_LOAD_ADDR) begin
      d[2:0] = st.load_armed;  // see R04
    end else if (a == SHARED_OUTPUT_ADDR) begin
      d[2:0] = st.out_level;   // see R05
    end
    return d;  // Upper bits stay zero, see R06
  endfunction

  logic [1:0] wc;
  logic [7:0] wf;

  always_comb begin
    next_s = s;
    wc = chan_of(s.aw_addr);
    wf = field_of(s.aw_addr);
    // Write channel: address and data accepted in either order
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
      next_s.awready = 1'b0;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_held = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
      next_s.wready = 1'b0;
    end
    // Counters run on their ticks; a software write in the same cycle wins
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      if (timer_tick[i] && s.enable[i]) begin
        next_s.count[i] = s.count[i] + 16'h1;
      end
      if (reload_done[i]) begin
        next_s.load_armed[i] = 1'b0;  // see R08
      end
    end
    unique case (s.wstate)
      bus_idle: begin
        if (s.aw_held && s.w_held) begin
          next_s.wstate = bus_resp;
          next_s.bresp = known(s.aw_addr) ? RESP_OKAY : RESP_SLVERR;
          if (s.w_strb[0] && known(s.aw_addr)) begin
            if (wc != 2'd3) begin
              unique case (wf)
                TIMER_COUNT_LOW_OFF:   next_s.count[wc][7:0]  = s.w_data[7:0];   // see R02
                TIMER_COUNT_HIGH_OFF:  next_s.count[wc][15:8] = s.w_data[7:0];   // see R01
                CHANNEL_CONTROL_OFF: begin
                  next_s.enable[wc]    = s.w_data[CONTROL_ENABLE_BIT];  // see R09
                  next_s.out_level[wc] = s.w_data[CONTROL_OUTPUT_BIT];
                end
                // Arming by software loses to a same-cycle reload completion
                CHANNEL_LOAD_CTRL_OFF: next_s.load_armed[wc] = s.w_data[LOAD_ARMED_BIT] & ~reload_done[wc];
                default:               next_s.bresp = RESP_SLVERR;
              endcase
            end else if (s.aw_addr == SHARED_ENABLE_ADDR) begin
              next_s.enable = s.w_data[2:0];     // see R03, R06, R09
            end else if (s.aw_addr == SHARED_LOAD_ADDR) begin
              next_s.load_armed = s.w_data[2:0] & ~reload_done;  // see R04, R08
            end else if (s.aw_addr == SHARED_OUTPUT_ADDR) begin
              next_s.out_level = s.w_data[2:0];  // see R05
            end
          end
        end
      end
      bus_resp: begin
        if (s_axi_bready) begin
          next_s.wstate  = bus_idle;
          next_s.aw_held = 1'b0;
          next_s.w_held  = 1'b0;
          next_s.awready = 1'b1;
          next_s.wready  = 1'b1;
        end
      end
      default: next_s.wstate = bus_idle;
    endcase
    // Read channel: one outstanding read, answer one cycle after acceptance
    if (s_axi_arvalid && s.arready) begin
      next_s.arready = 1'b0;
      next_s.rvalid  = 1'b1;
      next_s.rdata   = read_word(s, s_axi_araddr);
      next_s.rresp   = known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s.rvalid && s_axi_rready) begin
      next_s.rvalid  = 1'b0;
      next_s.arready = 1'b1;
    end
    // Synchronous reset: timer counts keep their contents across it
    if (!aresetn) begin
      next_s.awready    = 1'b1;
      next_s.wready     = 1'b1;
      next_s.aw_held    = 1'b0;
      next_s.w_held     = 1'b0;
      next_s.wstate     = bus_idle;
      next_s.bresp      = RESP_OKAY;
      next_s.arready    = 1'b1;
      next_s.rvalid     = 1'b0;
      next_s.rdata      = 32'h0;
      next_s.rresp      = RESP_OKAY;
      next_s.enable     = MIRROR_RESET;  // see R07
      next_s.load_armed = MIRROR_RESET;
      next_s.out_level  = MIRROR_RESET;
      next_s.count      = s.count;       // see R07
    end
  end

  always_ff @(posedge aclk) begin
    s <= next_s;
  end

  assign s_axi_awready        = s.awready;
  assign s_axi_wready         = s.wready;
  assign s_axi_bvalid         = (s.wstate == bus_resp);
  assign s_axi_bresp          = s.bresp;
  assign s_axi_arready        = s.arready;
  assign s_axi_rvalid         = s.rvalid;
  assign s_axi_rdata          = s.rdata;
  assign s_axi_rresp          = s.rresp;
  assign channel_enable       = s.enable;
  assign channel_load_armed   = s.load_armed;
  assign channel_output_level = s.out_level;

  sequence shared_enable_read_s;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == SHARED_ENABLE_ADDR;
  endsequence

  enable_view_read_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see R03
    shared_enable_read_s |=> s_axi_rvalid && s_axi_rdata == {29'h0, $past(channel_enable)})
    else $error("shared enable view read mismatch");

  load_view_read_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see R04
    s_axi_arvalid && s_axi_arready && s_axi_araddr == SHARED_LOAD_ADDR
    |=> s_axi_rdata[2:0] == $past(channel_load_armed))
    else $error("shared load view read mismatch");

  output_view_read_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see R05
    s_axi_arvalid && s_axi_arready && s_axi_araddr == SHARED_OUTPUT_ADDR
    |=> s_axi_rdata[2:0] == $past(channel_output_level))
    else $error("shared output view read mismatch");

  upper_bits_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see R06
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("unimplemented read bits not zero");

  mirror_reset_a: assert property (@(posedge aclk)  // see R07
    !aresetn |=> channel_enable == 3'h0 && channel_load_armed == 3'h0 && channel_output_level == 3'h0)
    else $error("mirror bits not cleared by reset");

  count_kept_a: assert property (@(posedge aclk)  // see R07
    !aresetn && $past(aresetn) |=> s.count == $past(s.count))
    else $error("timer count changed by reset");

  reload_clears_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see R08
    |reload_done |=> (channel_load_armed & $past(reload_done)) == 3'h0)
    else $error("load armed not cleared after reload");

  sequence shared_enable_write_s;
    s.wstate == bus_idle && s.aw_held && s.w_held && s.aw_addr == SHARED_ENABLE_ADDR && s.w_strb[0];
  endsequence

  shared_write_both_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see R09
    shared_enable_write_s |=> channel_enable == $past(s.w_data[2:0]) && s_axi_bvalid)
    else $error("shared write did not update enable in one cycle");

  high_byte_read_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see R01
    s_axi_arvalid && s_axi_arready && s_axi_araddr == CHANNEL_BASE + TIMER_COUNT_HIGH_OFF
    |=> s_axi_rdata[7:0] == $past(s.count[0][15:8]))
    else $error("timer high byte read mismatch");

  low_byte_read_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see R02
    s_axi_arvalid && s_axi_arready && s_axi_araddr == CHANNEL_BASE + TIMER_COUNT_LOW_OFF
    |=> s_axi_rdata[7:0] == $past(s.count[0][7:0]))
    else $error("timer low byte read mismatch");

  logic write_commit;
  assign write_commit = s.wstate == bus_idle && s.aw_held && s.w_held && s.w_strb[0];

  control_write_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see R09
    write_commit && s.aw_addr == CHANNEL_BASE + CHANNEL_CONTROL_OFF
    |=> channel_enable[0] == $past(s.w_data[CONTROL_ENABLE_BIT])
        && channel_output_level[0] == $past(s.w_data[CONTROL_OUTPUT_BIT]))
    else $error("control write did not reach the mirror ports");

  load_write_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see R09
    write_commit && s.aw_addr == CHANNEL_BASE + CHANNEL_LOAD_CTRL_OFF
    |=> channel_load_armed[0] == ($past(s.w_data[LOAD_ARMED_BIT]) && !$past(reload_done[0])))
    else $error("load control write did not reach the mirror port");

  tick_count_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see R02
    timer_tick[0] && channel_enable[0] && !(s.aw_held && s.w_held)
    |=> s.count[0] == $past(s.count[0]) + 16'h1)
    else $error("timer count did not advance on its tick");

  unmapped_write_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see R06
    s.wstate == bus_idle && s.aw_held && s.w_held && !known(s.aw_addr)
    |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR && $stable(channel_enable) && $stable(channel_output_level))
    else $error("unmapped write not refused");

  unmapped_read_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see R06
    s_axi_arvalid && s_axi_arready && !known(s_axi_araddr)
    |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");

endmodule

// ---- sim/testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pwm_regs_pkg::*;

  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [2:0]  timer_tick, reload_done, channel_enable, channel_load_armed, channel_output_level;
  int          miscompares = 0;
  int          tests_run = 0;

  pwm_timer_mirror_regs u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .timer_tick(timer_tick), .reload_done(reload_done),
    .channel_enable(channel_enable), .channel_load_armed(channel_load_armed),
    .channel_output_level(channel_output_level));

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [7:0] ch(input int n, input logic [7:0] off);
    return CHANNEL_BASE + 8'(n) * CHANNEL_STRIDE + off;
  endfunction

  // Bready drops after the response and one edge passes, so back-to-back calls never reassign it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
    check(what, rd, exp);
  endtask

  task automatic pulse(input logic [2:0] tick, input logic [2:0] done);
    timer_tick <= tick;
    reload_done <= done;
    @(posedge aclk);
    timer_tick <= 3'h0;
    reload_done <= 3'h0;
    @(posedge aclk);
  endtask

  task automatic t_mirrors_cleared;
    check("mirror ports", {23'h0, channel_enable, channel_load_armed, channel_output_level}, 32'h0);
    rchk(SHARED_ENABLE_ADDR, 32'h0, "enable view");
    rchk(SHARED_LOAD_ADDR, 32'h0, "load view");
    rchk(SHARED_OUTPUT_ADDR, 32'h0, "output view");
  endtask

  task automatic t_timer_bytes;
    for (int n = 0; n < 3; n++) begin
      wr(ch(n, TIMER_COUNT_LOW_OFF), 32'h01 + n);
      wr(ch(n, TIMER_COUNT_HIGH_OFF), 32'h80 + n);
    end
    // A write with the low lane disabled must leave the byte alone
    wr(ch(2, TIMER_COUNT_LOW_OFF), 32'hee, 4'h0);
    for (int n = 0; n < 3; n++) begin
      rchk(ch(n, TIMER_COUNT_LOW_OFF), 32'h01 + n, "count low");
      rchk(ch(n, TIMER_COUNT_HIGH_OFF), 32'h80 + n, "count high");
    end
  endtask

  task automatic t_control_mirrors;
    for (int n = 0; n < 3; n++) begin
      wr(ch(n, CHANNEL_CONTROL_OFF), 32'ha0);
      rchk(SHARED_ENABLE_ADDR, (32'h2 << n) - 1, "enable view");
      rchk(SHARED_OUTPUT_ADDR, (32'h2 << n) - 1, "output view");
    end
    check("level ports", {26'h0, channel_enable, channel_output_level}, 32'h3f);
    wr(SHARED_OUTPUT_ADDR, 32'hfa);
    rchk(SHARED_OUTPUT_ADDR, 32'h02, "output view");
    rchk(ch(0, CHANNEL_CONTROL_OFF), 32'h80, "control via view");
    rchk(ch(1, CHANNEL_CONTROL_OFF), 32'ha0, "control via view");
  endtask

  task automatic t_load_armed;
    for (int n = 0; n < 3; n++) wr(ch(n, CHANNEL_LOAD_CTRL_OFF), 32'h80);
    rchk(SHARED_LOAD_ADDR, 32'h07, "load view");
    pulse(3'h0, 3'b010);
    check("armed port", {29'h0, channel_load_armed}, 32'h5);
    rchk(SHARED_LOAD_ADDR, 32'h05, "load view");
    wr(SHARED_LOAD_ADDR, 32'hfc);
    rchk(SHARED_LOAD_ADDR, 32'h04, "load view");
    rchk(ch(0, CHANNEL_LOAD_CTRL_OFF), 32'h00, "load control");
  endtask

  task automatic t_tick_and_unmapped;
    wr(SHARED_ENABLE_ADDR, 32'h05);
    wr(ch(0, TIMER_COUNT_LOW_OFF), 32'hff);
    wr(ch(0, TIMER_COUNT_HIGH_OFF), 32'h12);
    pulse(3'b011, 3'h0);
    rchk(ch(0, TIMER_COUNT_LOW_OFF), 32'h00, "count low");
    rchk(ch(0, TIMER_COUNT_HIGH_OFF), 32'h13, "count high");
    rchk(ch(1, TIMER_COUNT_LOW_OFF), 32'h02, "idle count");
    wr(8'h80, 32'hff);
    check("bresp", rsp, RESP_SLVERR);
    rchk(8'h80, 32'h0, "unmapped");
    check("rresp", rsp, RESP_SLVERR);
  endtask

  task automatic t_mid_reset;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_mirrors_cleared();
    // Counts have no reset, so the value from before must survive
    rchk(ch(0, TIMER_COUNT_HIGH_OFF), 32'h13, "kept count");
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge aclk);
    miscompares++;
    close_out();
  end

  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    timer_tick = 3'h0;
    reload_done = 3'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_mirrors_cleared();
    t_timer_bytes();
    t_control_mirrors();
    t_load_armed();
    t_tick_and_unmapped();
    t_mid_reset();
    close_out();
  end
endmodule
